// File: acf_pkg.sv
// Constants, register map and state codes for the converter control block.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package acf_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CLKCFG = 8'h04;
   localparam logic [7:0] OFS_RESH = 8'h08;
   localparam logic [7:0] OFS_RESL = 8'h0C;
   localparam logic [7:0] OFS_ANALOG_PIN_SELECT = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN = 8'h1C;

   // Control register fields
   localparam int CTRL_JUSTIFY = 7;
   localparam int CTRL_VREF = 6;
   localparam int CTRL_CHAN_LO = 2;
   localparam int CTRL_GO = 1;
   localparam int CTRL_ON = 0;

   // Clock config field and irq bit position
   localparam int CLK_SEL_LO = 4;
   localparam int IRQ_DONE_BIT = 6;
   localparam logic [7:0] CLKCFG_MASK = 8'h70;
   localparam logic [7:0] IRQ_MASK = 8'h40;

   // Values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] CLK_SEL_RST = 3'h0;
   localparam logic [7:0] ANALOG_PIN_SELECT_RST = 8'hFF;
   localparam logic [7:0] IRQ_RST = 8'h00;

   // Converter geometry and abort delay in converter clock periods
   localparam int RES_BITS = 10;
   localparam logic [1:0] ABORT_TAD = 2'h2;

   // Divider selections and their divide ratios
   localparam logic [2:0] SEL_DIV2 = 3'h0;
   localparam logic [2:0] SEL_DIV8 = 3'h1;
   localparam logic [2:0] SEL_DIV32 = 3'h2;
   localparam logic [2:0] SEL_DIV4 = 3'h4;
   localparam logic [2:0] SEL_DIV16 = 3'h5;
   localparam logic [2:0] SEL_DIV64 = 3'h6;
   localparam logic [1:0] SEL_RC_LOW = 2'h3;

   // Conversion sequencer states
   typedef enum logic [1:0] {
      ACF_ACQ = 2'b00,
      ACF_CONV = 2'b01,
      ACF_ABORT = 2'b10
   } acf_state_t;
endpackage : acf_pkg

// File: acf_tad_gen.sv
// Converter clock period tick generator: divides the system clock or passes the RC tick.
// Assumes the RC oscillator tick input is already synchronous to mclk_i.
`timescale 1ns/1ns
`default_nettype none
module acf_tad_gen (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // Selection
   input wire logic [2:0] sel_i,
   input wire logic run_i,
   input wire logic frc_tick_i,
   // Tick out
   output logic tick_o
);
   // Terminal count for a selection; x11 does not use the counter
   function automatic logic [5:0] div_last(input logic [2:0] s);
      unique case (s)
         acf_pkg::SEL_DIV2: div_last = 6'h01;
         acf_pkg::SEL_DIV8: div_last = 6'h07;
         acf_pkg::SEL_DIV32: div_last = 6'h1F;
         acf_pkg::SEL_DIV4: div_last = 6'h03;
         acf_pkg::SEL_DIV16: div_last = 6'h0F;
         acf_pkg::SEL_DIV64: div_last = 6'h3F;
         default: div_last = 6'h00;
      endcase
   endfunction : div_last

   logic [5:0] cnt_r; // System clock divider count
   logic [5:0] cnt_nxt;
   logic rc_sel; // RC oscillator chosen

   assign rc_sel = (sel_i[1:0] == acf_pkg::SEL_RC_LOW); // [R2]

   // Counter restarts when idle so each run begins with a full period
   always_comb begin
      cnt_nxt = cnt_r;
      if (!run_i || rc_sel) begin
         cnt_nxt = 6'h00;
      end else if (cnt_r >= div_last(sel_i)) begin
         cnt_nxt = 6'h00; // [R1]
      end else begin
         cnt_nxt = cnt_r + 6'h01;
      end
   end

   // Register the count
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Tick: RC pulse or divider wrap
   assign tick_o = run_i && (rc_sel ? frc_tick_i : (cnt_r >= div_last(sel_i))); // [R1] [R2]
endmodule : acf_tad_gen
`default_nettype wire

// File: acf_fmt.sv
// Maps the stored 10-bit result onto the high and low result bytes.
// Purely combinational; the caller registers the read data.
`timescale 1ns/1ns
`default_nettype none
module acf_fmt (
   // Inputs
   input wire logic [9:0] result_i,
   input wire logic right_i,
   // Bytes
   output logic [7:0] high_o,
   output logic [7:0] low_o
);
   // Reserved positions read as zero
   always_comb begin
      if (right_i) begin
         high_o = {6'h00, result_i[9:8]}; // [R6]
         low_o = result_i[7:0]; // [R7]
      end else begin
         high_o = result_i[9:2]; // [R4]
         low_o = {result_i[1:0], 6'h00}; // [R5]
      end
   end
endmodule : acf_fmt
`default_nettype wire

// File: acf_top.sv
// Converter control block: AHB-Lite registers, conversion clock, SAR sequencer, result bytes.
// Assumes an analog core with a sample switch, a trial DAC and a comparator, all on mclk_i.
// Notes on behaviour
// (R1) Clock select codes other than x11 divide system clock
// (R2) Codes x11 use the RC oscillator tick
// (R3) Clock config holds bits 6-4 only
// (R4) Left: high byte holds bits 9-2
// (R5) Left: low byte top holds bits 1-0
// (R6) Right: high byte low holds bits 9-8
// (R7) Right: low byte holds bits 7-0
// (R8) Result bytes read-only, kept across reset
// (R9) Software waits acquisition before starting conversion
// (R10) Justify bit one means right justified
// (R11) Done clears go, sets flag, loads result
// (R12) Abort keeps result, waits two periods
// (R13) Justify change only remaps stored result
`timescale 1ns/1ns
`default_nettype none
module acf_top (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Analog core
   input wire logic frc_tick_i,
   input wire logic comp_i,
   output logic sample_o,
   output logic [9:0] trial_o,
   output logic [3:0] channel_o,
   output logic vref_sel_o,
   output logic [7:0] analog_pins_o,
   // Interrupt
   output logic irq_o
);
   // Bus data phase state
   logic dp_act_r; // Data phase pending
   logic dp_act_nxt;
   logic dp_wr_r; // Pending phase is a write
   logic dp_wr_nxt;
   logic [7:0] dp_addr_r; // Captured byte offset
   logic [7:0] dp_addr_nxt;
   logic rd_wait_r; // Read wait state done
   logic rd_wait_nxt;
   logic [31:0] rdata_r; // Registered read data
   logic [31:0] rdata_nxt;

   // Software registers
   logic [7:0] ctrl_r; // Converter control
   logic [7:0] ctrl_nxt;
   logic [2:0] clk_sel_r; // Conversion clock select
   logic [2:0] clk_sel_nxt;
   logic [7:0] analog_pin_select_r; // Analog pin select
   logic [7:0] analog_pin_select_nxt;
   logic [7:0] irq_stat_r; // Sticky flags
   logic [7:0] irq_stat_nxt;
   logic [7:0] irq_en_r; // Interrupt enables
   logic [7:0] irq_en_nxt;

   // Sequencer state
   acf_pkg::acf_state_t state_r;
   acf_pkg::acf_state_t state_nxt;
   logic [9:0] sar_r; // Bits decided so far
   logic [9:0] sar_nxt;
   logic [3:0] bit_r; // Bit under trial
   logic [3:0] bit_nxt;
   logic [1:0] wait_r; // Abort delay count
   logic [1:0] wait_nxt;
   logic [9:0] result_r; // Stored result, no reset
   logic [9:0] result_nxt;

   // Decoded strobes
   logic addr_ph; // Valid address phase
   logic wr_stb; // Write data phase now
   logic [7:0] wbyte; // Written byte
   logic tad_tick; // Converter clock period tick
   logic done; // Last bit decided
   logic sw_abort; // Software clears go mid-run
   logic [7:0] res_high;
   logic [7:0] res_low;

   // Converter clock period generator
   acf_tad_gen u_tad (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .sel_i(clk_sel_r),
      .run_i(state_r != acf_pkg::ACF_ACQ),
      .frc_tick_i(frc_tick_i),
      .tick_o(tad_tick)
   );

   // Result byte mapping, driven from the stored result only
   acf_fmt u_fmt (
      .result_i(result_r),
      .right_i(ctrl_r[acf_pkg::CTRL_JUSTIFY]), // [R10] [R13]
      .high_o(res_high),
      .low_o(res_low)
   );

   assign addr_ph = hsel_i && hready_i && htrans_i[1];
   assign wr_stb = dp_act_r && dp_wr_r;
   assign wbyte = hwdata_i[7:0];
   assign sw_abort = wr_stb && (dp_addr_r == acf_pkg::OFS_CTRL) && !wbyte[acf_pkg::CTRL_GO];
   // Completion needs the converter on, so the flag never rises without a loaded result
   assign done = (state_r == acf_pkg::ACF_CONV) && tad_tick && (bit_r == 4'h0) && ctrl_r[acf_pkg::CTRL_ON]; // [R11]

   // Read mux; unmapped and write-only offsets read zero
   function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [7:0] ctl, input logic [2:0] cs,
                                           input logic [7:0] rh, input logic [7:0] rl, input logic [7:0] an,
                                           input logic [7:0] st, input logic [7:0] en);
      unique case (a)
         acf_pkg::OFS_CTRL: read_byte = ctl;
         acf_pkg::OFS_CLKCFG: read_byte = {1'b0, cs, 4'h0}; // [R3]
         acf_pkg::OFS_RESH: read_byte = rh;
         acf_pkg::OFS_RESL: read_byte = rl;
         acf_pkg::OFS_ANALOG_PIN_SELECT: read_byte = an;
         acf_pkg::OFS_IRQ_STAT: read_byte = st;
         acf_pkg::OFS_IRQ_EN: read_byte = en;
         default: read_byte = 8'h00;
      endcase
   endfunction : read_byte

   // Bus phase tracking; reads insert one wait state so a preceding write has landed
   always_comb begin
      dp_act_nxt = dp_act_r;
      dp_wr_nxt = dp_wr_r;
      dp_addr_nxt = dp_addr_r;
      rd_wait_nxt = 1'b0;
      rdata_nxt = rdata_r;
      if (dp_act_r && !dp_wr_r && !rd_wait_r) begin
         // Wait cycle: sample the registers after any earlier write
         rd_wait_nxt = 1'b1;
         rdata_nxt = {24'h000000, read_byte(dp_addr_r, ctrl_r, clk_sel_r, res_high, res_low,
                                            analog_pin_select_r, irq_stat_r, irq_en_r)};
      end else if (hreadyout_o) begin
         dp_act_nxt = addr_ph;
         dp_wr_nxt = hwrite_i;
         dp_addr_nxt = {haddr_i[7:2], 2'b00};
      end
   end

   // Register bus state
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         dp_act_r <= 1'b0;
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
         rd_wait_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else begin
         dp_act_r <= dp_act_nxt;
         dp_wr_r <= dp_wr_nxt;
         dp_addr_r <= dp_addr_nxt;
         rd_wait_r <= rd_wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign hreadyout_o = !(dp_act_r && !dp_wr_r && !rd_wait_r);
   assign hresp_o = 1'b0;
   assign hrdata_o = rdata_r;

   // Software register updates, with hardware effects layered on top
   always_comb begin
      ctrl_nxt = ctrl_r;
      clk_sel_nxt = clk_sel_r;
      analog_pin_select_nxt = analog_pin_select_r;
      irq_en_nxt = irq_en_r;
      irq_stat_nxt = irq_stat_r;
      if (wr_stb) begin
         unique case (dp_addr_r)
            acf_pkg::OFS_CTRL: begin
               // Go only starts from acquisition with the converter on
               ctrl_nxt = wbyte;
               if (state_r == acf_pkg::ACF_ACQ) begin
                  ctrl_nxt[acf_pkg::CTRL_GO] = wbyte[acf_pkg::CTRL_GO] && ctrl_r[acf_pkg::CTRL_ON]
                                               && wbyte[acf_pkg::CTRL_ON];
               end else if (state_r == acf_pkg::ACF_ABORT) begin
                  ctrl_nxt[acf_pkg::CTRL_GO] = 1'b0;
               end else begin
                  ctrl_nxt[acf_pkg::CTRL_GO] = wbyte[acf_pkg::CTRL_GO] && wbyte[acf_pkg::CTRL_ON];
               end
            end
            acf_pkg::OFS_CLKCFG: clk_sel_nxt = wbyte[acf_pkg::CLK_SEL_LO +: 3]; // [R3]
            acf_pkg::OFS_ANALOG_PIN_SELECT: analog_pin_select_nxt = wbyte;
            acf_pkg::OFS_IRQ_EN: irq_en_nxt = wbyte & acf_pkg::IRQ_MASK;
            acf_pkg::OFS_IRQ_CLR: irq_stat_nxt = irq_stat_r & ~wbyte;
            default: ;
         endcase
      end
      if (done) begin
         ctrl_nxt[acf_pkg::CTRL_GO] = 1'b0; // [R11]
         irq_stat_nxt[acf_pkg::IRQ_DONE_BIT] = 1'b1; // [R11] set wins over clear
      end
      if (!ctrl_nxt[acf_pkg::CTRL_ON]) begin
         ctrl_nxt[acf_pkg::CTRL_GO] = 1'b0;
      end
   end

   // Software registers, reset to documented values
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ctrl_r <= acf_pkg::CTRL_RST;
         clk_sel_r <= acf_pkg::CLK_SEL_RST; // [R3]
         analog_pin_select_r <= acf_pkg::ANALOG_PIN_SELECT_RST;
         irq_stat_r <= acf_pkg::IRQ_RST;
         irq_en_r <= acf_pkg::IRQ_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         clk_sel_r <= clk_sel_nxt;
         analog_pin_select_r <= analog_pin_select_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_en_r <= irq_en_nxt;
      end
   end

   // Successive approximation sequencer, one bit per converter clock period
   always_comb begin
      state_nxt = state_r;
      sar_nxt = sar_r;
      bit_nxt = bit_r;
      wait_nxt = wait_r;
      result_nxt = result_r;
      unique case (state_r)
         acf_pkg::ACF_ACQ: begin
            // Hold capacitor tracks; software owns the settling time [R9]
            if (ctrl_r[acf_pkg::CTRL_GO]) begin
               state_nxt = acf_pkg::ACF_CONV;
               sar_nxt = 10'h000;
               bit_nxt = 4'(acf_pkg::RES_BITS - 1);
            end
         end
         acf_pkg::ACF_CONV: begin
            // Completion wins over an abort write in the same cycle
            if ((sw_abort && !done) || !ctrl_r[acf_pkg::CTRL_ON]) begin
               // Partial result dropped, previous one kept [R12]
               state_nxt = ctrl_r[acf_pkg::CTRL_ON] ? acf_pkg::ACF_ABORT : acf_pkg::ACF_ACQ;
               wait_nxt = 2'h0;
            end else if (tad_tick) begin
               sar_nxt[bit_r] = comp_i;
               if (bit_r == 4'h0) begin
                  state_nxt = acf_pkg::ACF_ACQ;
                  result_nxt = {sar_r[9:1], comp_i}; // [R11]
               end else begin
                  bit_nxt = bit_r - 4'h1;
               end
            end
         end
         acf_pkg::ACF_ABORT: begin
            // Two periods before acquisition restarts by itself
            if (!ctrl_r[acf_pkg::CTRL_ON]) begin
               state_nxt = acf_pkg::ACF_ACQ;
            end else if (tad_tick) begin
               if (wait_r == acf_pkg::ABORT_TAD - 2'h1) begin
                  state_nxt = acf_pkg::ACF_ACQ; // [R12]
               end
               wait_nxt = wait_r + 2'h1;
            end
         end
         default: state_nxt = acf_pkg::ACF_ACQ;
      endcase
   end

   // Sequencer registers; the result is left alone by reset [R8]
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state_r <= acf_pkg::ACF_ACQ;
         sar_r <= 10'h000;
         bit_r <= 4'h0;
         wait_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         sar_r <= sar_nxt;
         bit_r <= bit_nxt;
         wait_r <= wait_nxt;
      end
   end

   // Stored result has no reset so it survives soft resets
   always_ff @(posedge mclk_i) begin
      result_r <= result_nxt; // [R8]
   end

   // Trial code: decided bits plus the bit under test
   always_comb begin
      trial_o = sar_r;
      if (state_r == acf_pkg::ACF_CONV) begin
         trial_o[bit_r] = 1'b1;
      end
   end

   // Analog core controls
   assign sample_o = ctrl_r[acf_pkg::CTRL_ON] && (state_r == acf_pkg::ACF_ACQ);
   assign channel_o = ctrl_r[acf_pkg::CTRL_CHAN_LO +: 4];
   assign vref_sel_o = ctrl_r[acf_pkg::CTRL_VREF];
   assign analog_pins_o = analog_pin_select_r;
   assign irq_o = |(irq_stat_r & irq_en_r);
endmodule : acf_top
`default_nettype wire

// File: acf_top_sva.sv
// Port checker for the converter control block.
// Assumes one clock domain and a single AHB-Lite master.
`timescale 1ns/1ns
`default_nettype none
module acf_top_chk (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // Bus side
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // Core side and interrupt
   input wire logic sample_o,
   input wire logic [3:0] channel_o,
   input wire logic vref_sel_o,
   input wire logic [7:0] analog_pins_o,
   input wire logic irq_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   // Address phase taken at this edge
   wire logic take_w = hsel_i && hready_i && htrans_i[1];
   a_resp_okay: assert property (!hresp_o) else $error("error response seen");
   a_read_wait: assert property (take_w && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait state wrong");
   a_write_nowait: assert property (take_w && hwrite_i |=> hreadyout_o) else $error("write stalled");
   a_wait_single: assert property (!hreadyout_o |=> hreadyout_o) else $error("wait longer than one");
   a_upper_zero: assert property (hrdata_o[31:8] == 24'h0) else $error("upper read bits set");
   a_reset_quiet: assert property ($fell(srst_i) |-> !irq_o && !sample_o && analog_pins_o == 8'hFF)
      else $error("outputs not at reset values");
   a_chan_by_write: assert property ($changed(channel_o) |-> $past(srst_i) || $past(take_w && hwrite_i, 2))
      else $error("channel moved without write");
   a_vref_by_write: assert property ($changed(vref_sel_o) |-> $past(srst_i) || $past(take_w && hwrite_i, 2))
      else $error("reference moved without write");
   // Read data only moves after a read wait state
   a_rdata_hold: assert property ($changed(hrdata_o) |-> $past(srst_i) || $past(!hreadyout_o))
      else $error("read data moved");
endmodule : acf_top_chk
bind acf_top acf_top_chk u_chk (.mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .sample_o(sample_o), .channel_o(channel_o), .vref_sel_o(vref_sel_o),
   .analog_pins_o(analog_pins_o), .irq_o(irq_o));
`default_nettype wire

// File: acf_analog_model.sv
// Behavioural sample-and-hold plus comparator facing the converter.
// Assumes the input level is given as an ideal 10-bit code.
`timescale 1ns/1ns
`default_nettype none
module acf_analog_model (
   // Clock
   input wire logic mclk_i,
   // From converter
   input wire logic sample_i,
   input wire logic [9:0] trial_i,
   // Source level
   input wire logic [9:0] level_i,
   // Comparator
   output logic comp_o
);
   logic [9:0] hold_cap_r; // Hold capacitor charge as a code
   logic junk_r = 1'b0; // Meaningless output while sampling
   // Capacitor tracks the source only while the switch is closed
   always @(posedge mclk_i) begin
      if (sample_i) begin
         hold_cap_r <= level_i;
      end
      junk_r <= ~junk_r;
   end
   // No valid decision during acquisition, so it keeps toggling
   assign comp_o = sample_i ? junk_r : (hold_cap_r >= trial_i);
endmodule : acf_analog_model
`default_nettype wire

// File: adc_clock_and_result_format_tb.sv
// Self-checking bench for the converter control block.
// Assumes acf_top, its checker bind and the analog model are compiled.
`timescale 1ns/1ns
`default_nettype none
module adc_clock_and_result_format_tb;
   logic mclk_i, srst_i, hsel_i, hwrite_i, frc_tick_i, comp, hready, hresp, sample, vref, irq;
   logic [31:0] haddr_i, hwdata_i, hrdata, q; // Bus and last read word
   logic [1:0] htrans_i;
   logic [2:0] hsize_i;
   logic [9:0] trial, level;
   logic [3:0] chan;
   logic [7:0] pins;
   int fail_count, num_checks, n, lo;
   int cyc = 0, frc_cnt = 0; // Written only by the clocked process below
   // Clock codes, divide ratios (RC tick every 25) and source levels
   logic [2:0] sels [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
   int divs [8] = '{2, 8, 32, 4, 16, 64, 25, 25};
   logic [9:0] lvs [8] = '{10'h3FF, 10'h2A5, 10'h15A, 10'h000, 10'h200, 10'h1FF, 10'h0C3, 10'h2C7};
   acf_top u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .frc_tick_i(frc_tick_i), .comp_i(comp), .sample_o(sample), .trial_o(trial),
      .channel_o(chan), .vref_sel_o(vref), .analog_pins_o(pins), .irq_o(irq));
   acf_analog_model u_core (.mclk_i(mclk_i), .sample_i(sample), .trial_i(trial), .level_i(level),
      .comp_o(comp));
   // 10 MHz system clock
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   // RC tick at 400 kHz; hang guard
   always @(posedge mclk_i) begin
      frc_cnt <= (frc_cnt == 24) ? 0 : frc_cnt + 1;
      frc_tick_i <= (frc_cnt == 24);
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         stop_test();
      end
   end
   task stop_test();
      if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One single transfer; hready looked at mid-cycle, acted on at the edge
   task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      htrans_i <= 2'b10;
      do @(negedge mclk_i); while (hready !== 1'b1);
      @(posedge mclk_i);
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= {24'h0, d};
      do @(negedge mclk_i); while (hready !== 1'b1);
      q = hrdata;
      @(posedge mclk_i);
   endtask : bus
   task wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 8'h00);
      chk(q, e);
   endtask : rd
   // Count cycles until sample reaches v
   task wait_lvl(input logic v);
      n = 0;
      do begin
         @(negedge mclk_i);
         n++;
      end while (sample !== v && n < 1000);
      @(posedge mclk_i);
   endtask : wait_lvl
   task conv(input logic [2:0] s, input logic j, input logic [9:0] lv);
      wr(acf_pkg::OFS_CLKCFG, {1'b0, s, 4'h0});
      level <= lv;
      wr(acf_pkg::OFS_CTRL, {j, 7'h01});
      repeat (80) @(posedge mclk_i); // Acquisition of 8 us before go
      wr(acf_pkg::OFS_CTRL, {j, 7'h03});
      wait_lvl(1'b0);
      wait_lvl(1'b1);
   endtask : conv
   // Remap stored result under justify j
   task res(input logic j, input logic [9:0] lv);
      wr(acf_pkg::OFS_CTRL, {j, 7'h01});
      rd(acf_pkg::OFS_RESH, j ? {30'h0, lv[9:8]} : {24'h0, lv[9:2]});
      rd(acf_pkg::OFS_RESL, j ? {24'h0, lv[7:0]} : {24'h0, lv[1:0], 6'h0});
      rd(acf_pkg::OFS_CTRL, {24'h0, j, 7'h01});
   endtask : res
   initial begin
      {hsel_i, hwrite_i} = 2'h0;
      {haddr_i, hwdata_i, htrans_i, level} = '0;
      hsize_i = 3'h2;
      srst_i = 1'b1;
      {fail_count, num_checks} = '0;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      rd(acf_pkg::OFS_CTRL, 32'h0);
      rd(acf_pkg::OFS_ANALOG_PIN_SELECT, 32'hFF);
      rd(acf_pkg::OFS_IRQ_STAT, 32'h0);
      rd(8'h20, 32'h0);
      wr(acf_pkg::OFS_CLKCFG, 8'hFF);
      rd(acf_pkg::OFS_CLKCFG, 32'h70);
      wr(acf_pkg::OFS_ANALOG_PIN_SELECT, 8'h3C);
      @(posedge mclk_i); // Register lands on the edge that ends the write
      chk({24'h0, pins}, 32'h3C);
      wr(acf_pkg::OFS_CTRL, 8'h02);
      rd(acf_pkg::OFS_CTRL, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(acf_pkg::OFS_IRQ_EN, i[0] ? 8'h40 : 8'h00);
         conv(sels[i], i[0], lvs[i]);
         lo = (sels[i][1:0] == 2'h3) ? 26 : 2;
         chk({31'h0, n >= 10 * divs[i] - lo && n <= 10 * divs[i] + 3}, 32'h1);
         rd(acf_pkg::OFS_IRQ_STAT, 32'h40);
         chk({31'h0, irq}, {31'h0, i[0]});
         wr(acf_pkg::OFS_IRQ_CLR, 8'h40);
         @(posedge mclk_i); // Let the cleared flag settle
         chk({31'h0, irq}, 32'h0);
         res(i[0], lvs[i]);
         res(!i[0], lvs[i]);
      end
      conv(3'h0, 1'b0, 10'h155);
      wr(acf_pkg::OFS_RESH, 8'h5A);
      res(1'b0, 10'h155);
      wr(acf_pkg::OFS_IRQ_CLR, 8'h40);
      wr(acf_pkg::OFS_CTRL, 8'h03);
      repeat (6) @(posedge mclk_i);
      wr(acf_pkg::OFS_CTRL, 8'h01);
      wait_lvl(1'b1);
      chk({31'h0, n >= 3 && n <= 8}, 32'h1);
      res(1'b0, 10'h155);
      rd(acf_pkg::OFS_IRQ_STAT, 32'h0);
      wr(acf_pkg::OFS_CLKCFG, 8'h50);
      srst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      rd(acf_pkg::OFS_CLKCFG, 32'h0);
      res(1'b1, 10'h155);
      stop_test();
   end
endmodule : adc_clock_and_result_format_tb
`default_nettype wire
